//--- rtl/pop_unit.sv
// Pulse output port unit: APB registers, two pulse groups and pin multiplexer
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (RULE1) Control bit 0 set makes the four group-1 pins pulse outputs.
// (RULE2) Control bit 1 set makes the four group-0 pins pulse outputs.
// (RULE3) Both bits set drive all eight pins as pulse outputs together.
// (RULE4) Unselected group pins keep their normal port function.
// (RULE5) Software runs interval timers 0 and 2 in plain timer mode.
// (RULE6) Timer 2 zero copies data register 1 low nibble to group 1.
// (RULE7) Timer 0 zero copies data register 0 low nibble to group 0.
// (RULE8) Data bit zero drives its pin low, one drives it high.
// (RULE9) Software runs PWM timers 1 and 3 in modulation mode.
// (RULE10) Control bit 5 gates group 1 with PWM timer 3.
// (RULE11) Control bit 4 gates group 0 with PWM timer 1.
// (RULE12) Control bit 3 inverts group-0 output data.
// (RULE13) With modulation on, polarity bit inverts the modulated group-0 waveform.
// (RULE14) Pins hold last loaded level; modulation ANDs with the PWM output.
module pop_unit (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Timer events and modulation sources
    input  wire logic                  interval_timer_0_zero,
    input  wire logic                  interval_timer_2_zero,
    input  wire logic                  pwm_timer_1_out,
    input  wire logic                  pwm_timer_3_out,
    // Normal port function
    input  wire logic [7:0]            port_dout,
    input  wire logic [7:0]            port_oe_n,
    output logic      [7:0]            port_din,
    // Pins: [3:0] group 0, [7:4] group 1
    input  wire logic [7:0]            pin_sense,
    output pop_pkg::pop_pin_t          pin_drv
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]            data_g1_r;
    logic [7:0]            data_g0_r;
    logic [7:0]            wave_r;
    logic [31:0]           prdata_r;
    logic                  slverr_r;
    logic                  setup;
    logic                  access;
    logic                  wr_en;
    logic [7:0]            sync1_r;
    logic [7:0]            sync2_r;
    pop_pkg::pop_pin_t     pin_r;
    pop_pkg::pop_grp_cfg_t cfg_v [2];
    logic                  load_v [2];
    logic [3:0]            data_v [2];
    logic                  pwm_v [2];
    logic [3:0]            latch_v [2];
    logic [3:0]            level_v [2];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == pop_pkg::ADDR_DATA_G1) ||
                   (a == pop_pkg::ADDR_DATA_G0) ||
                   (a == pop_pkg::ADDR_WAVE);
    endfunction

    function automatic logic [7:0] read_mux(input logic [11:0] a);
        unique case (a)
            pop_pkg::ADDR_DATA_G1: read_mux = data_g1_r;
            pop_pkg::ADDR_DATA_G0: read_mux = data_g0_r;
            pop_pkg::ADDR_WAVE:    read_mux = wave_r & pop_pkg::WC_MASK;
            default:               read_mux = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------------
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wr_en  = access & pwrite & pstrb[0] & addr_hit(paddr);
    assign pready = 1'b1;

    // Read data and error captured in setup so both come from flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= {24'h00_0000, read_mux(paddr)};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            slverr_r <= 1'b0;
        end else if (setup) begin
            slverr_r <= ~addr_hit(paddr);
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = access & slverr_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_g1_r <= pop_pkg::RST_DATA;
        end else if (wr_en && paddr == pop_pkg::ADDR_DATA_G1) begin
            data_g1_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            data_g0_r <= pop_pkg::RST_DATA;
        end else if (wr_en && paddr == pop_pkg::ADDR_DATA_G0) begin
            data_g0_r <= pwdata[7:0];
        end
    end

    // Unused control bits are not stored, so they read zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wave_r <= pop_pkg::RST_WAVE;
        end else if (wr_en && paddr == pop_pkg::ADDR_WAVE) begin
            wave_r <= pwdata[7:0] & pop_pkg::WC_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Group setup
    // ------------------------------------------------------------------
    // Group 0 has the only polarity control
    assign cfg_v[0] = '{sel:    wave_r[pop_pkg::WC_SEL_G0],
                        pwm_en: wave_r[pop_pkg::WC_PWM_G0],
                        invert: wave_r[pop_pkg::WC_POL_G0]}; // [RULE2] [RULE11] [RULE12]
    assign cfg_v[1] = '{sel:    wave_r[pop_pkg::WC_SEL_G1],
                        pwm_en: wave_r[pop_pkg::WC_PWM_G1],
                        invert: 1'b0}; // [RULE1] [RULE10]

    assign load_v[0] = interval_timer_0_zero; // [RULE7]
    assign load_v[1] = interval_timer_2_zero; // [RULE6]
    assign data_v[0] = data_g0_r[3:0];
    assign data_v[1] = data_g1_r[3:0];
    assign pwm_v[0]  = pwm_timer_1_out;
    assign pwm_v[1]  = pwm_timer_3_out;

    // ------------------------------------------------------------------
    // Pulse groups
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < pop_pkg::NGRP; g++) begin : grp
            pop_group_out u_out (
                .clk_sys   (clk_sys),
                .rstn      (rstn),
                .load      (load_v[g]),
                .load_data (data_v[g]),
                .pwm_in    (pwm_v[g]),
                .cfg       (cfg_v[g]),
                .latch_q   (latch_v[g]),
                .level     (level_v[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin multiplexer, registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_r.o    <= pop_pkg::RST_PIN_O;
            pin_r.oe_n <= pop_pkg::RST_OE_N;
        end else begin
            for (int i = 0; i < pop_pkg::NGRP; i++) begin
                if (cfg_v[i].sel) begin
                    pin_r.o[i*4 +: 4]    <= level_v[i]; // [RULE1] [RULE2] [RULE3]
                    pin_r.oe_n[i*4 +: 4] <= 4'h0;
                end else begin
                    pin_r.o[i*4 +: 4]    <= port_dout[i*4 +: 4]; // [RULE4]
                    pin_r.oe_n[i*4 +: 4] <= port_oe_n[i*4 +: 4];
                end
            end
        end
    end

    assign pin_drv = pin_r;

    // ------------------------------------------------------------------
    // Pin input synchroniser back to the port logic
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= pin_sense;
            sync2_r <= sync1_r;
        end
    end

    assign port_din = sync2_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sel_group1_a: assert property ( // [RULE1]
        @(posedge clk_sys) disable iff (!rstn)
        wave_r[pop_pkg::WC_SEL_G1]
        |=> pin_drv.oe_n[7:4] == 4'h0
    ) else $error("group 1 pins not driven while selected");

    sel_group0_a: assert property ( // [RULE2]
        @(posedge clk_sys) disable iff (!rstn)
        wave_r[pop_pkg::WC_SEL_G0]
        |=> pin_drv.oe_n[3:0] == 4'h0
    ) else $error("group 0 pins not driven while selected");

    both_groups_a: assert property ( // [RULE3]
        @(posedge clk_sys) disable iff (!rstn)
        (wave_r[pop_pkg::WC_SEL_G1] && wave_r[pop_pkg::WC_SEL_G0])
        |=> (pin_drv.oe_n == 8'h00)
            && (pin_drv.o[7:4] == $past(level_v[1]))
            && (pin_drv.o[3:0] == $past(level_v[0]))
    ) else $error("both groups not driven together");

    // Sampled reset keeps the release edge out: the pins still hold reset values there
    port_pass_a: assert property ( // [RULE4]
        @(posedge clk_sys) disable iff (!rstn)
        (rstn && !wave_r[pop_pkg::WC_SEL_G1])
        |=> (pin_drv.o[7:4] == $past(port_dout[7:4]))
            && (pin_drv.oe_n[7:4] == $past(port_oe_n[7:4]))
    ) else $error("unselected group 1 lost port function");

    load_group1_a: assert property ( // [RULE6]
        @(posedge clk_sys) disable iff (!rstn)
        interval_timer_2_zero
        |=> latch_v[1] == $past(data_g1_r[3:0])
    ) else $error("group 1 not loaded on timer 2 zero");

    load_group0_a: assert property ( // [RULE7]
        @(posedge clk_sys) disable iff (!rstn)
        interval_timer_0_zero
        |=> latch_v[0] == $past(data_g0_r[3:0])
    ) else $error("group 0 not loaded on timer 0 zero");

    level_map_a: assert property ( // [RULE8]
        @(posedge clk_sys) disable iff (!rstn)
        (interval_timer_2_zero && !interval_timer_0_zero)
        ##1 (wave_r[pop_pkg::WC_SEL_G1] && !wave_r[pop_pkg::WC_PWM_G1])
        |=> pin_drv.o[7:4] == $past(data_g1_r[3:0], 2)
    ) else $error("group 1 pin level differs from loaded data");

    pwm_group1_a: assert property ( // [RULE10]
        @(posedge clk_sys) disable iff (!rstn)
        (wave_r[pop_pkg::WC_SEL_G1] && wave_r[pop_pkg::WC_PWM_G1])
        |=> pin_drv.o[7:4] == ($past(latch_v[1]) & {4{$past(pwm_timer_3_out)}})
    ) else $error("group 1 not gated by pwm timer 3");

    pwm_group0_a: assert property ( // [RULE11]
        @(posedge clk_sys) disable iff (!rstn)
        (wave_r[pop_pkg::WC_SEL_G0] && wave_r[pop_pkg::WC_PWM_G0]
            && !wave_r[pop_pkg::WC_POL_G0] && !pwm_timer_1_out)
        |=> pin_drv.o[3:0] == 4'h0
    ) else $error("group 0 not gated by pwm timer 1");

    polarity_g0_a: assert property ( // [RULE12]
        @(posedge clk_sys) disable iff (!rstn)
        (wave_r[pop_pkg::WC_SEL_G0] && !wave_r[pop_pkg::WC_PWM_G0])
        |=> pin_drv.o[3:0] == ($past(latch_v[0]) ^ {4{$past(wave_r[pop_pkg::WC_POL_G0])}})
    ) else $error("group 0 polarity wrong");

    pwm_invert_a: assert property ( // [RULE13]
        @(posedge clk_sys) disable iff (!rstn)
        (wave_r[pop_pkg::WC_SEL_G0] && wave_r[pop_pkg::WC_PWM_G0]
            && wave_r[pop_pkg::WC_POL_G0])
        |=> pin_drv.o[3:0] == ~($past(latch_v[0]) & {4{$past(pwm_timer_1_out)}})
    ) else $error("modulated group 0 waveform not inverted");

    hold_level_a: assert property ( // [RULE14]
        @(posedge clk_sys) disable iff (!rstn)
        !interval_timer_2_zero [*2]
        |-> $stable(latch_v[1])
    ) else $error("group 1 level changed without an update event");

    hold_group0_a: assert property ( // [RULE14]
        @(posedge clk_sys) disable iff (!rstn)
        !interval_timer_0_zero [*2]
        |-> $stable(latch_v[0])
    ) else $error("group 0 level changed without an update event");

    level_map_g0_a: assert property ( // [RULE8]
        @(posedge clk_sys) disable iff (!rstn)
        (interval_timer_0_zero && !interval_timer_2_zero)
        ##1 (wave_r[pop_pkg::WC_SEL_G0] && !wave_r[pop_pkg::WC_PWM_G0]
            && !wave_r[pop_pkg::WC_POL_G0])
        |=> pin_drv.o[3:0] == $past(data_g0_r[3:0], 2)
    ) else $error("group 0 pin level differs from loaded data");

    plain_group1_a: assert property ( // [RULE8]
        @(posedge clk_sys) disable iff (!rstn)
        (wave_r[pop_pkg::WC_SEL_G1] && !wave_r[pop_pkg::WC_PWM_G1])
        |=> pin_drv.o[7:4] == $past(latch_v[1])
    ) else $error("group 1 output not a plain copy of its latch");

    port_pass_g0_a: assert property ( // [RULE4]
        @(posedge clk_sys) disable iff (!rstn)
        (rstn && !wave_r[pop_pkg::WC_SEL_G0])
        |=> (pin_drv.o[3:0] == $past(port_dout[3:0]))
            && (pin_drv.oe_n[3:0] == $past(port_oe_n[3:0]))
    ) else $error("unselected group 0 lost port function");

    strobe_guard_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (access && pwrite && !pstrb[0])
        |=> $stable(data_g1_r) && $stable(data_g0_r) && $stable(wave_r)
    ) else $error("register changed by a write without its byte strobe");

    unmapped_write_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (access && pwrite && !addr_hit(paddr))
        |=> $stable(data_g1_r) && $stable(data_g0_r) && $stable(wave_r)
    ) else $error("register changed by a write to an unmapped address");

    error_cause_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        pslverr |-> !addr_hit(paddr)
    ) else $error("error flagged for a mapped address");

    apb_error_a: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (setup && !addr_hit(paddr)) ##1 access
        |-> pslverr && pready
    ) else $error("unmapped access not flagged");

endmodule

`default_nettype wire

//--- rtl/pop_pkg.sv
// Package for the pulse output port unit: map, field positions, reset values, carriers
package pop_pkg;

    // ------------------------------------------------------------------
    // Register map (printed index, byte address is four times it)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W        = 12;
    localparam logic [7:0]  IDX_DATA_G1   = 8'h1c;
    localparam logic [7:0]  IDX_DATA_G0   = 8'h1d;
    localparam logic [7:0]  IDX_WAVE_CTRL = 8'h62;
    localparam logic [11:0] ADDR_DATA_G1  = {2'h0, IDX_DATA_G1, 2'h0};
    localparam logic [11:0] ADDR_DATA_G0  = {2'h0, IDX_DATA_G0, 2'h0};
    localparam logic [11:0] ADDR_WAVE     = {2'h0, IDX_WAVE_CTRL, 2'h0};

    // ------------------------------------------------------------------
    // Waveform output control fields
    // ------------------------------------------------------------------
    localparam int unsigned WC_SEL_G1 = 0;
    localparam int unsigned WC_SEL_G0 = 1;
    localparam int unsigned WC_POL_G0 = 3;
    localparam int unsigned WC_PWM_G0 = 4;
    localparam int unsigned WC_PWM_G1 = 5;
    localparam logic [7:0]  WC_MASK   = 8'h3b;

    // ------------------------------------------------------------------
    // Reset values and geometry
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_DATA  = 8'h00;
    localparam logic [7:0]  RST_WAVE  = 8'h00;
    localparam logic [7:0]  RST_PIN_O = 8'h00;
    localparam logic [7:0]  RST_OE_N  = 8'hff;
    localparam logic [3:0]  RST_LATCH = 4'h0;
    localparam int unsigned NGRP      = 2;
    localparam int unsigned GRP_W     = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe_n;
    } pop_pin_t;

    typedef struct packed {
        logic sel;
        logic pwm_en;
        logic invert;
    } pop_grp_cfg_t;

endpackage

//--- rtl/pop_group_out.sv
// One four-pin pulse group: update latch, modulation gate and polarity
`timescale 1ns/1ps
`default_nettype none

module pop_group_out (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    // Update event and data
    input  wire logic                load,
    input  wire logic [3:0]          load_data,
    // Modulation source and setup
    input  wire logic                pwm_in,
    input  wire pop_pkg::pop_grp_cfg_t cfg,
    // Results
    output logic      [3:0]          latch_q,
    output logic      [3:0]          level
);

    logic [3:0] latch_r;
    logic       gate;

    // ------------------------------------------------------------------
    // Latch loaded only on the timer zero event
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            latch_r <= pop_pkg::RST_LATCH;
        end else if (load) begin
            latch_r <= load_data; // [RULE6] [RULE7] [RULE14]
        end
    end

    // Gate is open when modulation is off
    assign gate    = ~cfg.pwm_en | pwm_in; // [RULE10] [RULE11]
    // AND with modulation first, then invert, so the modulated waveform is inverted as a whole
    assign level   = (latch_r & {4{gate}}) ^ {4{cfg.invert}}; // [RULE8] [RULE12] [RULE13] [RULE14]
    assign latch_q = latch_r;

endmodule

`default_nettype wire

//--- verif/pop_motor_drv_model.sv
// Behavioural model of the motor driver inputs hanging on the eight pulse pins
`timescale 1ns/1ps
`default_nettype none

module pop_motor_drv_model (
    // Pins from the unit
    input  wire pop_pkg::pop_pin_t pin_drv,
    // Resolved wire levels
    output logic [7:0]             pin_lvl
);
    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // Driver inputs carry pull-downs, so a released pin reads low, never its last value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_lvl[i] = pin_drv.oe_n[i] ? 1'b0 : pin_drv.o[i];
        end
    end
endmodule

`default_nettype wire

//--- verif/pulse_output_port_unit_test.sv
// Self-checking bench for the pulse output port unit
`timescale 1ns/1ps
`default_nettype none

module pulse_output_port_unit_test;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic       pwm1;
        logic       pwm3;
        logic [7:0] pdout;
        logic [7:0] poen;
        logic [7:0] exp_o;
        logic [7:0] exp_oe;
    } pop_row_t;

    logic              clk_sys   = 1'b0;
    logic              rstn      = 1'b0;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [11:0]       paddr     = 12'h000;
    logic [31:0]       pwdata    = 32'h0000_0000;
    logic [3:0]        pstrb     = 4'hf;
    logic              t0_zero   = 1'b0;
    logic              t2_zero   = 1'b0;
    logic              pwm1      = 1'b0;
    logic              pwm3      = 1'b0;
    logic [7:0]        port_dout = 8'h00;
    logic [7:0]        port_oe_n = 8'hff;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [7:0]        port_din;
    logic [7:0]        pin_lvl;
    pop_pkg::pop_pin_t pin_drv;
    int                fail_count      = 0;
    int                samples_checked = 0;

    // Data registers hold 8'hc5 / 8'h3a, so group 1 nibble is 5, group 0 nibble is a
    pop_row_t rows [10] = '{
        '{8'h00, 1'b0, 1'b0, 8'h3c, 8'h0f, 8'h3c, 8'h0f},
        '{8'h01, 1'b0, 1'b0, 8'h3c, 8'hff, 8'h5c, 8'h0f},
        '{8'h02, 1'b0, 1'b0, 8'h3c, 8'hff, 8'h3a, 8'hf0},
        '{8'h03, 1'b0, 1'b0, 8'h3c, 8'hff, 8'h5a, 8'h00},
        '{8'h0b, 1'b0, 1'b0, 8'h3c, 8'hff, 8'h55, 8'h00},
        '{8'h13, 1'b0, 1'b1, 8'h3c, 8'hff, 8'h50, 8'h00},
        '{8'h33, 1'b1, 1'b1, 8'h3c, 8'hff, 8'h5a, 8'h00},
        '{8'h23, 1'b1, 1'b0, 8'h3c, 8'hff, 8'h0a, 8'h00},
        '{8'h1b, 1'b0, 1'b0, 8'h3c, 8'hff, 8'h5f, 8'h00},
        '{8'h1b, 1'b1, 1'b0, 8'h3c, 8'hff, 8'h55, 8'h00}
    };

    always #25 clk_sys = ~clk_sys;

    pop_unit u_pop_unit (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .interval_timer_0_zero(t0_zero), .interval_timer_2_zero(t2_zero),
        .pwm_timer_1_out(pwm1), .pwm_timer_3_out(pwm3), .port_dout(port_dout),
        .port_oe_n(port_oe_n), .port_din(port_din), .pin_sense(pin_lvl), .pin_drv(pin_drv)
    );

    pop_motor_drv_model u_pop_motor_drv_model (.pin_drv(pin_drv), .pin_lvl(pin_lvl));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; holds everything until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] strb, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        pstrb   <= strb;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [11:0] a, input logic [7:0] d, input logic experr);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, 4'hf, r, e);
        check({31'h0, e}, {31'h0, experr}, "write error flag");
    endtask

    task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, 4'hf, r, e);
        check(r, exp, "read data");
        check({31'h0, e}, {31'h0, experr}, "read error flag");
    endtask

    task automatic fire(input logic z0, input logic z2);
        @(posedge clk_sys);
        t0_zero <= z0;
        t2_zero <= z2;
        @(posedge clk_sys);
        t0_zero <= 1'b0;
        t2_zero <= 1'b0;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        settle(5);
        check({16'h0, pin_drv}, {16'h0, pop_pkg::RST_PIN_O, pop_pkg::RST_OE_N}, "reset pins");
        @(posedge clk_sys);
        rstn <= 1'b1;
        rreg(pop_pkg::ADDR_WAVE, 32'h0, 1'b0);
        rreg(pop_pkg::ADDR_DATA_G1, 32'h0, 1'b0);
        wreg(pop_pkg::ADDR_WAVE, 8'hff, 1'b0);
        rreg(pop_pkg::ADDR_WAVE, {24'h0, pop_pkg::WC_MASK}, 1'b0);
        wreg(12'h078, 8'h55, 1'b1);
        rreg(12'h078, 32'h0, 1'b1);
        apb(1'b1, pop_pkg::ADDR_DATA_G1, 8'h77, 4'h0, r, e);
        rreg(pop_pkg::ADDR_DATA_G1, 32'h0, 1'b0);
        wreg(pop_pkg::ADDR_DATA_G1, 8'hc5, 1'b0);
        wreg(pop_pkg::ADDR_DATA_G0, 8'h3a, 1'b0);
        rreg(pop_pkg::ADDR_DATA_G0, 32'h3a, 1'b0);
        // Timers paced by single-cycle zero pulses, PWM levels as plain inputs
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            pwm1      <= rows[i].pwm1;
            pwm3      <= rows[i].pwm3;
            port_dout <= rows[i].pdout;
            port_oe_n <= rows[i].poen;
            wreg(pop_pkg::ADDR_WAVE, rows[i].ctrl, 1'b0);
            fire(1'b1, 1'b1);
            settle(5);
            check({24'h0, pin_drv.o}, {24'h0, rows[i].exp_o}, "pin level");
            check({24'h0, pin_drv.oe_n}, {24'h0, rows[i].exp_oe}, "pin enable");
            check({24'h0, port_din}, {24'h0, rows[i].exp_o & ~rows[i].exp_oe}, "din");
        end
        wreg(pop_pkg::ADDR_WAVE, 8'h03, 1'b0);
        wreg(pop_pkg::ADDR_DATA_G1, 8'h0a, 1'b0);
        wreg(pop_pkg::ADDR_DATA_G0, 8'h05, 1'b0);
        settle(4);
        check({24'h0, pin_drv.o}, 32'h5a, "hold without event");
        fire(1'b0, 1'b1);
        // Latch loads at the edge that ends the pulse; pins follow one edge later
        @(negedge clk_sys);
        check({24'h0, pin_drv.o}, 32'h5a, "update too early");
        settle(1);
        check({24'h0, pin_drv.o}, 32'haa, "group 1 update");
        fire(1'b1, 1'b0);
        settle(2);
        check({24'h0, pin_drv.o}, 32'ha5, "group 0 update");
        wreg(pop_pkg::ADDR_WAVE, 8'h01, 1'b0);
        wreg(pop_pkg::ADDR_DATA_G0, 8'h0c, 1'b0);
        fire(1'b1, 1'b0);
        wreg(pop_pkg::ADDR_WAVE, 8'h03, 1'b0);
        settle(3);
        check({24'h0, pin_drv.o}, 32'hac, "load while unselected");
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(negedge clk_sys);
        check({16'h0, pin_drv}, {16'h0, pop_pkg::RST_PIN_O, pop_pkg::RST_OE_N}, "mid reset");
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        rreg(pop_pkg::ADDR_WAVE, 32'h0, 1'b0);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
